// *** hdl/mmt_defs.svh ***
// Address map, field positions, vectors and reset values of the memory map unit
//
// Contract
// [RQ1] Program counter is 13 bits wide and reaches 8192 words of 14 bits.
// [RQ2] Program addresses run from 0000h to 1FFFh and nothing else holds code.
// [RQ3] Fetching starts at address zero after reset; an interrupt vectors to address four.
// [RQ4] Each instruction is one 14-bit word, so the fetch bus is 14 bits wide.
// [RQ5] Four data banks; the first 32 locations of each bank are special registers.
// [RQ6] General RAM answers only at 20h-7Fh, A0h-EFh and 120h-16Fh; bank 3 has none.
// [RQ7] Any unimplemented data location reads as zero.
// [RQ8] Direct access takes its bank from the two direct bank-select bits.
// [RQ9] Indirect access uses the pointer plus the indirect bank bit for the bank pair.
// [RQ10] The pointer can be aimed at program memory to read constants as data.
// [RQ11] Register-to-register moves pass the working register and take two cycles.
// [RQ12] Word 2089h holds the current-loop DAC trim in 7-4, voltage-loop in 3-0.
// [RQ13] DAC trims are signed: 0111 maximum, 0000 centre, 1000 minimum, monotonic.
// [RQ14] Word 208Ah holds two 4-bit error amplifier trims for channel 1.
// [RQ15] Error amplifier trims are signed: 0111 maximum, 0000 centre, 1000 minimum.
// [RQ16] Firmware copies the error amplifier trim word into its trim register.
// [RQ17] Word 208Bh holds the 10-bit channel 1 amplifier gain, real gain is value/1024.
// [RQ18] Word 208Ch holds the 10-bit channel 2 amplifier gain, scaled the same.
// [RQ19] Unused upper bits of the calibration words read back as one.
// [RQ20] Indirect bank bit one reaches banks 2 and 3, zero reaches banks 0 and 1.
// [RQ21] Core registers are mirrored at the same low offset in every bank.
`ifndef MMT_DEFS_SVH
`define MMT_DEFS_SVH

// Program memory
`define MMT_PC_W 13
`define MMT_INSTR_W 14
`define MMT_PM_DEPTH 8192
`define MMT_PM_TOP 14'h1FFF
`define MMT_RESET_VEC 13'h0000
`define MMT_INT_VEC 13'h0004
`define MMT_PC_ONE 13'h0001

// Register bus map
`define MMT_BUS_AW 14
`define MMT_ADDR_DAC_CH1 14'h2089
`define MMT_ADDR_EA_CH1 14'h208A
`define MMT_ADDR_GAIN_CH1 14'h208B
`define MMT_ADDR_GAIN_CH2 14'h208C
`define MMT_ADDR_STATUS 14'h2100
`define MMT_ADDR_PTR 14'h2101
`define MMT_ADDR_EA_REG 14'h2102
`define MMT_ADDR_PROG_HI 14'h2103
`define MMT_ADDR_WREG 14'h2104

// Calibration word layout
`define MMT_CAL8_FILL 6'h3F
`define MMT_GAIN_FILL 4'hF
`define MMT_GAIN_W 10
`define MMT_GAIN_SCALE 1024
`define MMT_TRIM_W 4
`define MMT_NUM_TRIMS 4

// Data memory decode
`define MMT_DADDR_W 9
`define MMT_SFR_TOP 7'h1F
`define MMT_FILE_INDIRECT 7'h00
`define MMT_FILE_PCL 7'h02
`define MMT_FILE_STATUS 7'h03
`define MMT_FILE_PTR 7'h04
`define MMT_GPR0_LO 9'h020
`define MMT_GPR0_HI 9'h07F
`define MMT_GPR1_LO 9'h0A0
`define MMT_GPR1_HI 9'h0EF
`define MMT_GPR2_LO 9'h120
`define MMT_GPR2_HI 9'h16F
`define MMT_DATA_ZERO 8'h00

// Status register and program-read window fields
`define MMT_ST_IRP 7
`define MMT_ST_RP_HI 6
`define MMT_ST_RP_LO 5
`define MMT_ST_RESET 8'h18
`define MMT_ST_WMASK 8'hE7
`define MMT_PROG_EN_BIT 7
`define MMT_PROG_HI_W 5

`endif

// *** hdl/mmt_pkg.sv ***
// Types shared by the memory map unit and its users
`include "mmt_defs.svh"

package mmt_pkg;

    // Register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [`MMT_BUS_AW-1:0] addr;
        logic [`MMT_INSTR_W-1:0] wdata;
    } mmt_bus_req_t;

    // Core data access: direct file address, or indirect through the pointer
    typedef struct packed {
        logic rd;
        logic wr;
        logic ind;
        logic [6:0] file;
        logic [7:0] wdata;
    } mmt_dreq_t;

    // Program counter control from the core sequencer
    typedef struct packed {
        logic step;
        logic jump;
        logic int_ack;
        logic [`MMT_PC_W-1:0] target;
    } mmt_pcctl_t;

    // Register-to-register move request
    typedef struct packed {
        logic req;
        logic src_ind;
        logic [6:0] src;
        logic [6:0] dst;
    } mmt_move_t;

    // Decoded trim levels, offset binary
    typedef struct packed {
        logic [`MMT_TRIM_W-1:0] dac_cur;
        logic [`MMT_TRIM_W-1:0] dac_volt;
        logic [`MMT_TRIM_W-1:0] ea_cur;
        logic [`MMT_TRIM_W-1:0] ea_volt;
    } mmt_trim_t;

    typedef enum logic [1:0] {
        MOV_IDLE = 2'b00,
        MOV_LOAD = 2'b01,
        MOV_STORE = 2'b10
    } mmt_mov_st_t;

endpackage

// *** hdl/mmt_trim_dec.sv ***
// Signed trim code to monotonic offset-binary level
module mmt_trim_dec #(
    parameter int W = 4
) (
    // Signed trim field
    input wire logic [W-1:0] i_code,
    // Level: all zeros at minimum, MSB alone at centre, all ones at maximum
    output logic [W-1:0] o_level
);

    // Flipping the sign bit maps 1000..0111 onto 0000..1111 in order
    assign o_level = {~i_code[W-1], i_code[W-2:0]}; // [RQ13] [RQ15]

endmodule

// *** hdl/mmt_memmap.sv ***
// Memory map unit: program memory, banked data memory and calibration words
`include "mmt_defs.svh"

module mmt_memmap #(
    parameter int PM_DEPTH = `MMT_PM_DEPTH,
    parameter logic [7:0] CAL_DAC_CH1 = 8'h00,
    parameter logic [7:0] CAL_EA_CH1 = 8'h00,
    parameter logic [`MMT_GAIN_W-1:0] CAL_GAIN_CH1 = 10'h280,
    parameter logic [`MMT_GAIN_W-1:0] CAL_GAIN_CH2 = 10'h280
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Register bus
    input wire mmt_pkg::mmt_bus_req_t i_bus,
    output logic [`MMT_INSTR_W-1:0] o_bus_rdata,
    // Instruction fetch
    input wire mmt_pkg::mmt_pcctl_t i_pcctl,
    output logic [`MMT_PC_W-1:0] o_pc,
    output logic [`MMT_INSTR_W-1:0] o_instr,
    // Core data access
    input wire mmt_pkg::mmt_dreq_t i_dreq,
    input wire mmt_pkg::mmt_move_t i_move,
    output logic [7:0] o_dat_rdata,
    output logic o_dat_rvalid,
    output logic o_move_busy,
    output logic [7:0] o_wreg,
    // Core register views
    output logic [7:0] o_status,
    output logic [7:0] o_pointer,
    // Trim and gain outputs
    output mmt_pkg::mmt_trim_t o_trim,
    output logic [`MMT_GAIN_W-1:0] o_gain_ch1,
    output logic [`MMT_GAIN_W-1:0] o_gain_ch2
);
    import mmt_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Storage

    // Program memory: one 14-bit instruction per word, 13-bit address
    logic [`MMT_INSTR_W-1:0] pm [0:PM_DEPTH-1]; // [RQ1] [RQ4]
    // General RAM spans the whole 9-bit space; only the decoded ranges are used
    logic [7:0] general_ram [0:(1<<`MMT_DADDR_W)-1];

    logic [`MMT_PC_W-1:0] pc_r;
    logic [`MMT_PC_W-1:0] pc_nxt;
    logic [7:0] status_r;
    logic [7:0] status_nxt;
    logic [7:0] ptr_r;
    logic [7:0] ptr_nxt;
    logic [7:0] ea_reg_r;
    logic [7:0] prog_hi_r;
    logic [7:0] wreg_r;
    logic [7:0] wreg_nxt;
    mmt_mov_st_t mov_st_r;
    mmt_mov_st_t mov_st_nxt;
    logic [6:0] mov_dst_r;
    logic [`MMT_INSTR_W-1:0] bus_rdata_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // Program counter

    // Interrupt vector wins over a jump, a jump over a plain step
    assign pc_nxt = i_pcctl.int_ack ? `MMT_INT_VEC : // [RQ3]
                    i_pcctl.jump ? i_pcctl.target :
                    i_pcctl.step ? pc_r + `MMT_PC_ONE : pc_r; // [RQ2]

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus decode

    wire bus_pm_hit = i_bus.addr <= `MMT_PM_TOP; // [RQ2]
    wire bus_wr_status = i_bus.wr && i_bus.addr == `MMT_ADDR_STATUS;
    wire bus_wr_ptr = i_bus.wr && i_bus.addr == `MMT_ADDR_PTR;
    wire bus_wr_ea = i_bus.wr && i_bus.addr == `MMT_ADDR_EA_REG;
    wire bus_wr_prog = i_bus.wr && i_bus.addr == `MMT_ADDR_PROG_HI;
    wire bus_wr_pm = i_bus.wr && bus_pm_hit;
    wire [`MMT_PC_W-1:0] bus_pm_addr = i_bus.addr[`MMT_PC_W-1:0];

    // Calibration words; unused upper bits read as ones
    wire [`MMT_INSTR_W-1:0] dac_word = {`MMT_CAL8_FILL, CAL_DAC_CH1}; // [RQ12] [RQ19]
    wire [`MMT_INSTR_W-1:0] ea_word = {`MMT_CAL8_FILL, CAL_EA_CH1}; // [RQ14] [RQ19]
    wire [`MMT_INSTR_W-1:0] gain1_word = {`MMT_GAIN_FILL, CAL_GAIN_CH1}; // [RQ17] [RQ19]
    wire [`MMT_INSTR_W-1:0] gain2_word = {`MMT_GAIN_FILL, CAL_GAIN_CH2}; // [RQ18] [RQ19]

    // Read mux; calibration words have no write path at all
    always_comb begin
        case (i_bus.addr)
            `MMT_ADDR_DAC_CH1: bus_rdata_nxt = dac_word;
            `MMT_ADDR_EA_CH1: bus_rdata_nxt = ea_word;
            `MMT_ADDR_GAIN_CH1: bus_rdata_nxt = gain1_word;
            `MMT_ADDR_GAIN_CH2: bus_rdata_nxt = gain2_word;
            `MMT_ADDR_STATUS: bus_rdata_nxt = {6'h00, status_r};
            `MMT_ADDR_PTR: bus_rdata_nxt = {6'h00, ptr_r};
            `MMT_ADDR_EA_REG: bus_rdata_nxt = {6'h00, ea_reg_r};
            `MMT_ADDR_PROG_HI: bus_rdata_nxt = {6'h00, prog_hi_r};
            `MMT_ADDR_WREG: bus_rdata_nxt = {6'h00, wreg_r};
            default: bus_rdata_nxt = bus_pm_hit ? pm[bus_pm_addr] : 14'h0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data access source: the move engine owns the data path while busy

    wire mov_load = mov_st_r == MOV_LOAD;
    wire mov_store = mov_st_r == MOV_STORE;
    wire mov_idle = mov_st_r == MOV_IDLE;
    // Core accesses are ignored while a move is running
    wire core_rd = mov_idle && i_dreq.rd;
    wire core_wr = mov_idle && i_dreq.wr;

    wire [6:0] d_file = mov_load ? i_move.src : mov_store ? mov_dst_r : i_dreq.file;
    wire d_ind_req = mov_load ? i_move.src_ind : mov_store ? 1'b0 : i_dreq.ind;
    wire d_wr = core_wr || mov_store;
    wire [7:0] d_wdata = mov_store ? wreg_r : i_dreq.wdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Address formation

    // Access to file 0 of any bank goes through the pointer
    wire use_ind = d_ind_req || d_file == `MMT_FILE_INDIRECT; // [RQ21]
    // Indirect bank bit picks the bank pair, pointer gives the rest
    wire [`MMT_DADDR_W-1:0] ind_addr = {status_r[`MMT_ST_IRP], ptr_r}; // [RQ9] [RQ20]
    // Direct bank bits pick one of four banks
    wire [`MMT_DADDR_W-1:0] dir_addr =
        {status_r[`MMT_ST_RP_HI:`MMT_ST_RP_LO], d_file}; // [RQ8]
    wire [`MMT_DADDR_W-1:0] eff_addr = use_ind ? ind_addr : dir_addr;
    wire [6:0] eff_off = eff_addr[6:0];

    // Pointer aimed at program memory returns the low byte of a code word
    wire prog_mode = use_ind && prog_hi_r[`MMT_PROG_EN_BIT]; // [RQ10]
    wire [`MMT_PC_W-1:0] prog_addr = {prog_hi_r[`MMT_PROG_HI_W-1:0], ptr_r};
    wire [`MMT_INSTR_W-1:0] prog_word = pm[prog_addr];

    // Pointer at its own indirect slot is a null access
    wire ind_null = use_ind && eff_off == `MMT_FILE_INDIRECT;

    // Core registers decode on the low offset alone, so they mirror in every bank
    wire in_sfr = eff_off <= `MMT_SFR_TOP; // [RQ5]
    wire sel_status = !prog_mode && eff_off == `MMT_FILE_STATUS; // [RQ21]
    wire sel_ptr = !prog_mode && eff_off == `MMT_FILE_PTR; // [RQ21]
    wire sel_pcl = !prog_mode && eff_off == `MMT_FILE_PCL; // [RQ21]

    // General RAM windows; bank 3 has none
    wire sel_gpr = !prog_mode && !in_sfr && !ind_null &&
        ((eff_addr >= `MMT_GPR0_LO && eff_addr <= `MMT_GPR0_HI) ||
         (eff_addr >= `MMT_GPR1_LO && eff_addr <= `MMT_GPR1_HI) ||
         (eff_addr >= `MMT_GPR2_LO && eff_addr <= `MMT_GPR2_HI)); // [RQ6]

    // Everything outside the decoded locations reads as zero
    wire [7:0] d_rdata = prog_mode ? prog_word[7:0] :
                         sel_status ? status_r :
                         sel_ptr ? ptr_r :
                         sel_pcl ? pc_r[7:0] :
                         sel_gpr ? general_ram[eff_addr] : `MMT_DATA_ZERO; // [RQ7]

    wire gpr_we = d_wr && sel_gpr;
    wire dat_wr_status = d_wr && sel_status;
    wire dat_wr_ptr = d_wr && sel_ptr;

    ////////////////////////////////////////////////////////////////////////////////
    // Core register next values; the bus wins over the core on a collision

    // Time-out and power-down bits are never written
    assign status_nxt = bus_wr_status ?
        (status_r & ~`MMT_ST_WMASK) | (i_bus.wdata[7:0] & `MMT_ST_WMASK) :
        dat_wr_status ? (status_r & ~`MMT_ST_WMASK) | (d_wdata & `MMT_ST_WMASK) :
        status_r;
    assign ptr_nxt = bus_wr_ptr ? i_bus.wdata[7:0] : dat_wr_ptr ? d_wdata : ptr_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Move engine: source into the working register, then out to the destination

    always_comb begin
        case (mov_st_r)
            MOV_IDLE: mov_st_nxt = i_move.req ? MOV_LOAD : MOV_IDLE; // [RQ11]
            MOV_LOAD: mov_st_nxt = MOV_STORE; // [RQ11]
            MOV_STORE: mov_st_nxt = MOV_IDLE;
            default: mov_st_nxt = MOV_IDLE;
        endcase
    end

    // Loaded in the first cycle of a move; core cannot reach it directly here
    assign wreg_nxt = mov_load ? d_rdata : wreg_r; // [RQ11]

    ////////////////////////////////////////////////////////////////////////////////
    // Trim decode

    wire [`MMT_NUM_TRIMS-1:0][`MMT_TRIM_W-1:0] trim_code;
    wire [`MMT_NUM_TRIMS-1:0][`MMT_TRIM_W-1:0] trim_level;

    // DAC trims come straight from the calibration word
    assign trim_code[3] = CAL_DAC_CH1[7:4]; // [RQ12]
    assign trim_code[2] = CAL_DAC_CH1[3:0]; // [RQ12]
    // Amplifier trims act only once firmware has copied the word across
    assign trim_code[1] = ea_reg_r[7:4]; // [RQ16]
    assign trim_code[0] = ea_reg_r[3:0]; // [RQ16]

    genvar gi;
    generate
        for (gi = 0; gi < `MMT_NUM_TRIMS; gi++) begin : g_trim
            mmt_trim_dec #(
                .W(`MMT_TRIM_W)
            ) u_dec (
                .i_code(trim_code[gi]),
                .o_level(trim_level[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Memory writes; arrays carry no reset

    always_ff @(posedge i_sys_clk) begin
        if (bus_wr_pm) begin
            pm[bus_pm_addr] <= i_bus.wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (gpr_we) begin
            general_ram[eff_addr] <= d_wdata; // [RQ6]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control registers

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pc_r <= `MMT_RESET_VEC; // [RQ3]
            status_r <= `MMT_ST_RESET;
            ptr_r <= 8'h00;
            mov_st_r <= MOV_IDLE;
            mov_dst_r <= 7'h00;
            wreg_r <= 8'h00;
        end else begin
            pc_r <= pc_nxt;
            status_r <= status_nxt;
            ptr_r <= ptr_nxt;
            mov_st_r <= mov_st_nxt;
            mov_dst_r <= (mov_idle && i_move.req) ? i_move.dst : mov_dst_r;
            wreg_r <= wreg_nxt;
        end
    end

    // Software-owned trim copy and program-read window
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ea_reg_r <= 8'h00;
            prog_hi_r <= 8'h00;
        end else begin
            ea_reg_r <= bus_wr_ea ? i_bus.wdata[7:0] : ea_reg_r; // [RQ16]
            prog_hi_r <= bus_wr_prog ? i_bus.wdata[7:0] : prog_hi_r; // [RQ10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output registers

    // Fetch follows the counter one cycle later, so the first word after reset is 0000h
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_instr <= 14'h0000;
            o_bus_rdata <= 14'h0000;
        end else begin
            o_instr <= pm[pc_r]; // [RQ3] [RQ4]
            // Read data stands for one cycle only, zero otherwise
            o_bus_rdata <= i_bus.rd ? bus_rdata_nxt : 14'h0000;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_dat_rdata <= 8'h00;
            o_dat_rvalid <= 1'b0;
        end else begin
            o_dat_rdata <= core_rd ? d_rdata : `MMT_DATA_ZERO; // [RQ7]
            o_dat_rvalid <= core_rd;
        end
    end

    // Mirrors of internal state; registered from the next values, so they match their source in the same cycle
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pc <= `MMT_RESET_VEC;
            o_status <= `MMT_ST_RESET;
            o_pointer <= 8'h00;
            o_wreg <= 8'h00;
            o_move_busy <= 1'b0;
        end else begin
            o_pc <= pc_nxt;
            o_status <= status_nxt;
            o_pointer <= ptr_nxt;
            o_wreg <= wreg_nxt;
            o_move_busy <= mov_st_nxt != MOV_IDLE;
        end
    end

    // Trim levels and gain figures; gain is a fraction of full scale 1024
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_trim <= '0;
            o_gain_ch1 <= 10'h000;
            o_gain_ch2 <= 10'h000;
        end else begin
            o_trim <= trim_level; // [RQ13] [RQ15]
            o_gain_ch1 <= CAL_GAIN_CH1; // [RQ17]
            o_gain_ch2 <= CAL_GAIN_CH2; // [RQ18]
        end
    end

endmodule

// *** sim/mmt_memmap_asserts.sv ***
// Assertions on the memory map unit ports
module mmt_memmap_asserts import mmt_pkg::*; #(
    parameter logic [7:0] CAL_DAC_CH1 = 8'h00,
    parameter logic [9:0] CAL_GAIN_CH1 = 10'h000
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Requests
    input wire mmt_pkg::mmt_bus_req_t i_bus,
    input wire mmt_pkg::mmt_pcctl_t i_pcctl,
    input wire mmt_pkg::mmt_dreq_t i_dreq,
    input wire mmt_pkg::mmt_move_t i_move,
    // Answers
    input wire logic [13:0] o_bus_rdata,
    input wire logic [12:0] o_pc,
    input wire logic o_dat_rvalid,
    input wire logic o_move_busy,
    input wire mmt_pkg::mmt_trim_t o_trim
);
    // One clock domain
    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst);
    ////////////////////////
    // Calibration reads
    cal_dac_read_a: assert property ($past(i_bus.rd) && $past(i_bus.addr) == 14'h2089
        |-> o_bus_rdata == {6'h3F, CAL_DAC_CH1}) else $error("dac word");
    cal_gain_read_a: assert property ($past(i_bus.rd) && $past(i_bus.addr) == 14'h208B
        |-> o_bus_rdata == {4'hF, CAL_GAIN_CH1}) else $error("gain word");
    // Fetch control
    int_vector_a: assert property (i_pcctl.int_ack |=> o_pc == 13'h0004)
        else $error("no vector");
    jump_target_a: assert property (i_pcctl.jump && !i_pcctl.int_ack
        |=> o_pc == $past(i_pcctl.target)) else $error("no jump");
    pc_step_a: assert property (i_pcctl.step && !i_pcctl.jump && !i_pcctl.int_ack
        |=> o_pc == $past(o_pc) + 13'h0001) else $error("no step");
    // Data port and moves
    rd_valid_a: assert property (i_dreq.rd && !o_move_busy |=> o_dat_rvalid)
        else $error("no read answer");
    move_two_a: assert property (i_move.req && !o_move_busy
        |=> o_move_busy [*2] ##1 !o_move_busy) else $error("move length");
    // Trim levels
    trim_level_a: assert property ($past(i_nrst) |-> o_trim.dac_cur == (CAL_DAC_CH1[7:4] ^ 4'h8)
        && o_trim.dac_volt == (CAL_DAC_CH1[3:0] ^ 4'h8)) else $error("trim level");
endmodule
bind mmt_memmap mmt_memmap_asserts #(.CAL_DAC_CH1(CAL_DAC_CH1), .CAL_GAIN_CH1(CAL_GAIN_CH1)) chk (
    .i_sys_clk, .i_nrst, .i_bus, .i_pcctl, .i_dreq, .i_move,
    .o_bus_rdata, .o_pc, .o_dat_rvalid, .o_move_busy, .o_trim
);

// *** sim/mmt_core_model.sv ***
// Core-side model of fetch, data and move requests
module mmt_core_model import mmt_pkg::*; (
    // Clock
    input wire logic i_sys_clk,
    // Requests into the unit
    output mmt_pkg::mmt_pcctl_t o_pcctl,
    output mmt_pkg::mmt_dreq_t o_dreq,
    output mmt_pkg::mmt_move_t o_move,
    // Answers
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid
);
    // Idle at start
    initial begin
        o_pcctl = '0;
        o_dreq = '0;
        o_move = '0;
    end
    // One fetch-control cycle
    task automatic pc_op(input logic st, jp, ia, input logic [12:0] t);
        @(posedge i_sys_clk);
        o_pcctl <= '{st, jp, ia, t};
        @(posedge i_sys_clk);
        o_pcctl <= '0;
    endtask
    // One data access, answer taken a cycle later
    task automatic dacc(input logic wr, ind, input logic [6:0] f,
                        input logic [7:0] d, output logic [7:0] q, output logic v);
        @(posedge i_sys_clk);
        o_dreq <= '{!wr, wr, ind, f, d};
        @(posedge i_sys_clk);
        o_dreq <= '0;
        #1 q = i_rdata;
        v = i_rvalid;
    endtask
    // Move; source holds through the load cycle
    task automatic mv(input logic [6:0] s, t);
        @(posedge i_sys_clk);
        o_move <= '{1'b1, 1'b0, s, t};
        @(posedge i_sys_clk);
        o_move.req <= 1'b0;
        @(posedge i_sys_clk);
        o_move <= '0;
    endtask
endmodule

// *** sim/tb_memory_map_and_trim_words.sv ***
// Random self-checking bench of the memory map unit
module tb_memory_map_and_trim_words import mmt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] DAC = 8'h78;
    localparam logic [7:0] EA = 8'h81;
    localparam logic [9:0] G1 = 10'h3A5;
    localparam logic [9:0] G2 = 10'h001;
    // Ports and state
    logic i_sys_clk = 1'b0;
    logic i_nrst = 1'b0;
    mmt_bus_req_t i_bus = '0;
    mmt_pcctl_t i_pcctl;
    mmt_dreq_t i_dreq;
    mmt_move_t i_move;
    logic [13:0] o_bus_rdata, o_instr;
    logic [12:0] o_pc;
    logic [7:0] o_dat_rdata, o_wreg, o_status, o_pointer;
    logic o_dat_rvalid, o_move_busy;
    mmt_trim_t o_trim;
    logic [9:0] o_gain_ch1, o_gain_ch2;
    logic [13:0] pm [logic [12:0]];
    logic [7:0] mem [0:511];
    int errors = 0;
    int cmp_count = 0;
    int seed = 32'h6020192E;
    ////////////////////////
    // 250 MHz clock
    always #2 i_sys_clk = ~i_sys_clk;
    mmt_memmap #(.CAL_DAC_CH1(DAC), .CAL_EA_CH1(EA), .CAL_GAIN_CH1(G1), .CAL_GAIN_CH2(G2)) dut (
        .i_sys_clk, .i_nrst, .i_bus, .o_bus_rdata, .i_pcctl, .o_pc, .o_instr,
        .i_dreq, .i_move, .o_dat_rdata, .o_dat_rvalid, .o_move_busy, .o_wreg,
        .o_status, .o_pointer, .o_trim, .o_gain_ch1, .o_gain_ch2
    );
    mmt_core_model core (
        .i_sys_clk, .o_pcctl(i_pcctl), .o_dreq(i_dreq), .o_move(i_move),
        .i_rdata(o_dat_rdata), .i_rvalid(o_dat_rvalid)
    );
    ////////////////////////
    // Compare and count
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Register bus write and read
    task automatic bwr(input logic [13:0] a, d);
        @(posedge i_sys_clk);
        i_bus <= '{1'b1, 1'b0, a, d};
        @(posedge i_sys_clk);
        i_bus <= '0;
    endtask
    task automatic brd(input logic [13:0] a, output logic [13:0] q);
        @(posedge i_sys_clk);
        i_bus <= '{1'b0, 1'b1, a, 14'h0000};
        @(posedge i_sys_clk);
        i_bus <= '0;
        #1 q = o_bus_rdata;
    endtask
    // Expected calibration words
    function automatic logic [13:0] calw(input int i);
        return (i == 0) ? {6'h3F, DAC} : (i == 1) ? {6'h3F, EA} : (i == 2) ? {4'hF, G1} : {4'hF, G2};
    endfunction
    function automatic logic general_ram(input logic [8:0] a);
        return (a >= 9'h020 && a <= 9'h07F) || (a >= 9'h0A0 && a <= 9'h0EF)
            || (a >= 9'h120 && a <= 9'h16F);
    endfunction
    // Verdict and end of run
    task automatic summarize();
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Watchdog, well past the test length
    initial begin
        #200000;
        errors++;
        summarize();
    end
    ////////////////////////
    // Main sequence
    initial begin
        logic [13:0] q;
        logic [7:0] b, d;
        logic v;
        logic [12:0] a;
        logic [6:0] f, edges [4];
        logic [8:0] da;
        edges = '{7'h20, 7'h6F, 7'h70, 7'h7F};
        repeat (3) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        #1 chk("pc reset", 16'(o_pc), 16'h0000);
        // Calibration words ignore writes
        for (int i = 0; i < 4; i++) begin
            bwr(14'h2089 + 14'(i), 14'h0000);
            brd(14'h2089 + 14'(i), q);
            chk("cal word", 16'(q), 16'(calw(i)));
        end
        chk("dac cur", 16'(o_trim.dac_cur), 16'(DAC[7:4] ^ 4'h8));
        chk("dac volt", 16'(o_trim.dac_volt), 16'(DAC[3:0] ^ 4'h8));
        chk("gain 1", 16'(o_gain_ch1), 16'(G1));
        chk("gain 2", 16'(o_gain_ch2), 16'(G2));
        brd(14'h208D, q);
        chk("unmapped", 16'(q), 16'h0000);
        // Firmware copies the amplifier trim
        brd(14'h208A, q);
        bwr(14'h2102, q);
        @(posedge i_sys_clk);
        #1 chk("ea cur", 16'(o_trim.ea_cur), 16'(EA[7:4] ^ 4'h8));
        chk("ea volt", 16'(o_trim.ea_volt), 16'(EA[3:0] ^ 4'h8));
        $display("test cal done");
        // Program memory ends and random words
        for (int i = 0; i < 10; i++) begin
            a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1FFF : 13'($random(seed));
            pm[a] = 14'($random(seed));
            bwr({1'b0, a}, pm[a]);
        end
        brd(14'h2000, q);
        chk("above code", 16'(q), 16'h0000);
        foreach (pm[k]) begin
            brd({1'b0, k}, q);
            chk("pm word", 16'(q), 16'(pm[k]));
            core.pc_op(1'b0, 1'b1, 1'b0, k);
            #1 chk("pc jump", 16'(o_pc), 16'(k));
            @(posedge i_sys_clk);
            #1 chk("instr", 16'(o_instr), 16'(pm[k]));
        end
        core.pc_op(1'b1, 1'b0, 1'b0, 13'h0000);
        #1 chk("pc wrap", 16'(o_pc), 16'h0000);
        core.pc_op(1'b1, 1'b1, 1'b1, 13'($random(seed)));
        #1 chk("pc vector", 16'(o_pc), 16'h0004);
        core.pc_op(1'b1, 1'b0, 1'b0, 13'h0000);
        #1 chk("pc step", 16'(o_pc), 16'h0005);
        $display("test fetch done");
        // Direct access per bank
        for (int bk = 0; bk < 4; bk++) begin
            bwr(14'h2100, 14'(bk << 5));
            core.dacc(1'b0, 1'b0, 7'h03, 8'h00, d, v);
            chk("status", 16'({v, d}), 16'({2'b10, 2'(bk), 5'h18}));
            for (int j = 0; j < 10; j++) begin
                f = (j < 4) ? edges[j] : 7'(32 + {$random(seed)} % 96);
                da = {2'(bk), f};
                b = 8'($random(seed));
                core.dacc(1'b1, 1'b0, f, b, d, v);
                mem[da] = general_ram(da) ? b : 8'h00;
                core.dacc(1'b0, 1'b0, f, 8'h00, d, v);
                chk("data", 16'({v, d}), 16'({1'b1, mem[da]}));
            end
        end
        core.dacc(1'b0, 1'b0, 7'h50, 8'h00, d, v);
        chk("bank 3 ram", 16'(d), 16'h0000);
        for (int bk = 0; bk < 4; bk++) begin
            bwr(14'h2100, 14'(bk << 5));
            core.dacc(1'b0, 1'b0, 7'h20, 8'h00, d, v);
            chk("bank", 16'(d), 16'(mem[{2'(bk), 7'h20}]));
        end
        $display("test direct done");
        // Indirect access and program window
        bwr(14'h2101, 14'h0025);
        bwr(14'h2100, 14'h0080);
        #1 chk("views", 16'({o_status, o_pointer}), 16'h9825);
        core.dacc(1'b1, 1'b1, 7'h00, 8'hA5, d, v);
        bwr(14'h2100, 14'h0040);
        core.dacc(1'b0, 1'b0, 7'h25, 8'h00, d, v);
        chk("upper half", 16'(d), 16'h00A5);
        bwr(14'h2100, 14'h0000);
        core.dacc(1'b1, 1'b0, 7'h25, 8'h3C, d, v);
        core.dacc(1'b0, 1'b0, 7'h00, 8'h00, d, v);
        chk("lower half", 16'(d), 16'h003C);
        bwr(14'h2103, 14'h009F);
        bwr(14'h2101, 14'h00FF);
        core.dacc(1'b0, 1'b1, 7'h00, 8'h00, d, v);
        chk("prog window", 16'(d), 16'(pm[13'h1FFF][7:0]));
        bwr(14'h2103, 14'h0000);
        $display("test indirect done");
        // Register move
        core.dacc(1'b1, 1'b0, 7'h30, 8'h5A, d, v);
        core.mv(7'h30, 7'h31);
        #1 chk("busy store", 16'(o_move_busy), 16'h0001);
        @(posedge i_sys_clk);
        #1 chk("wreg", 16'({o_move_busy, o_wreg}), 16'h005A);
        core.dacc(1'b0, 1'b0, 7'h31, 8'h00, d, v);
        chk("move dst", 16'(d), 16'h005A);
        $display("test move done");
        summarize();
    end
endmodule
